// File: pci_cs_pkg.sv
// constants for the pci command and status register pair
// assumes one 16-bit config access port, halfword aligned offsets
package pci_cs_pkg;
    // ------------------------------------------------------------
    // access port shape
    // ------------------------------------------------------------
    localparam int          REG_W           = 16;
    localparam int          OFF_W           = 8;
    localparam int          BE_W            = 2;
    localparam logic [1:0]  BE_FULL         = 2'h3;
    localparam logic [7:0]  OFF_BUS_CONTROL = 8'h04;
    localparam logic [7:0]  OFF_EVENT_FLAGS = 8'h06;

    // ------------------------------------------------------------
    // pci_bus_control fields
    // ------------------------------------------------------------
    localparam int CMD_IO_EN       = 0;
    localparam int CMD_MEM_EN      = 1;
    localparam int CMD_MASTER_EN   = 2;
    localparam int CMD_SPECIAL     = 3;
    localparam int CMD_MWI         = 4;
    localparam int CMD_PARITY_RESP = 6;
    localparam int CMD_SERR_EN     = 8;
    localparam int CMD_FAST_B2B    = 9;
    localparam logic [15:0] CMD_RESET    = 16'h0006;
    localparam logic [15:0] CMD_WRITABLE = 16'h0146;

    // ------------------------------------------------------------
    // pci_event_flags fields
    // ------------------------------------------------------------
    localparam int ST_MASTER_PARITY = 8;
    localparam int ST_FAST_B2B_CAP  = 7;
    localparam int ST_SIG_TABORT    = 11;
    localparam int ST_RCV_TABORT    = 12;
    localparam int ST_RCV_MABORT    = 13;
    localparam int ST_SIG_SERR      = 14;
    localparam int ST_PARITY_DET    = 15;
    localparam logic [15:0] ST_FIXED_ONES = 16'h0080;
    localparam logic [15:0] ST_STICKY     = 16'hf900;
    localparam logic [15:0] ST_RESET      = 16'h0000;
    localparam logic [15:0] ST_RESERVED   = 16'h007f;
    localparam logic [15:0] ST_DEVSEL     = 16'h0600;
endpackage

// File: event_flags.sv
// sticky event flag bank, write-one-to-clear
// assumes set and clear come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module event_flags #(
    parameter int              WIDTH   = 16,
    parameter logic [15:0]     RST_VAL = 16'h0000
) (
    input  wire logic             clk_sys_in, // system clock
    input  wire logic             srst_in,    // sync reset, high
    input  wire logic [WIDTH-1:0] set_in,     // event pulses
    input  wire logic [WIDTH-1:0] clear_in,   // clear mask
    output logic      [WIDTH-1:0] flags_out   // flag state
);
    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } ef_state_t;

    ef_state_t st;
    ef_state_t next_st;

    always_comb
    begin
        next_st = st;
        // set wins so an event in the clearing cycle survives
        next_st.flags = (st.flags & ~clear_in) | set_in;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
            st.flags <= RST_VAL[WIDTH-1:0];
        else
            st <= next_st;
    end

    assign flags_out = st.flags;
endmodule // event_flags
`default_nettype wire

// File: pci_access_gate.sv
// gates processor requests and target decode by the enable bits
// assumes hits and requests are one-cycle pulses on this clock
`timescale 1ns/1ps
`default_nettype none
module pci_access_gate (
    input  wire logic clk_sys_in,     // system clock
    input  wire logic srst_in,        // sync reset, high
    input  wire logic master_en_in,   // bus mastering allowed
    input  wire logic mem_en_in,      // memory target allowed
    input  wire logic err_rep_en_in,  // transfer error report enable
    input  wire logic cpu_req_in,     // processor request to pci
    input  wire logic cpu_write_in,   // request is a write
    input  wire logic tgt_mem_hit_in, // memory space address hit
    input  wire logic tgt_io_hit_in,  // io space address hit
    input  wire logic tgt_spec_in,    // special cycle seen
    output logic      cpu_fwd_out,    // pass request to master
    output logic      cpu_drop_out,   // write data discarded
    output logic      transfer_error_ack_out, // error acknowledge
    output logic      tgt_claim_out   // claim as target
);
    typedef struct packed {
        logic fwd;
        logic drop;
        logic err_ack;
        logic claim;
    } gate_state_t;

    gate_state_t st;
    gate_state_t next_st;
    logic        blocked;

    assign blocked = cpu_req_in & ~master_en_in;

    always_comb
    begin
        next_st       = st;
        next_st.fwd   = cpu_req_in & master_en_in;
        next_st.drop  = blocked & cpu_write_in;
        next_st.err_ack = blocked & ~cpu_write_in
                        & err_rep_en_in;
        // io and special cycles never reach the claim term
        next_st.claim = tgt_mem_hit_in & mem_en_in
                        & ~tgt_io_hit_in & ~tgt_spec_in;
    end

    // claim one edge after the hit keeps devsel fast
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
            st <= '0;
        else
            st <= next_st;
    end

    assign cpu_fwd_out   = st.fwd;
    assign cpu_drop_out  = st.drop;
    assign transfer_error_ack_out = st.err_ack;
    assign tgt_claim_out = st.claim;
endmodule // pci_access_gate
`default_nettype wire

// File: pci_command_status_regs.sv
// pci command and status register pair of the host bridge
// assumes config accesses, error events and requests are
// single-cycle pulses from logic on clk_sys_in
`timescale 1ns/1ps
`default_nettype none
// Operation
// - reserved bits reset and read as zero
// - command bit 9 fixed zero
// - command bit 8 gates serr driver
// - address parity reported needs bits 8, 6
// - command bit 6 enables parity response
// - command bit 4 fixed zero
// - command bit 3 zero, ignore special cycles
// - command bit 2 enables mastering, resets one
// - blocked writes dropped, reads get error ack if report enabled
// - command bit 1 enables memory target
// - command bit 0 zero, never claim io
// - full-width status writes clear ones, never set
// - bit 15 on any parity error
// - bit 14 when serr is asserted
// - bit 13 on master abort, not special
// - bit 12 on received target abort
// - bit 11 on signalled target abort
// - bits 10-9 zero, fast devsel decode
// - bit 8 on master parity with response
// - status bit 7 fixed one
module pci_command_status_regs
(
    input  wire logic                       clk_sys_in,    // clock
    input  wire logic                       srst_in,       // reset
    input  wire logic                       cfg_valid_in,  // access
    input  wire logic                       cfg_write_in,  // write
    input  wire logic [pci_cs_pkg::OFF_W-1:0] cfg_offset_in, // offset
    input  wire logic [pci_cs_pkg::BE_W-1:0]  cfg_byte_en_in, // lanes
    input  wire logic [pci_cs_pkg::REG_W-1:0] cfg_wdata_in,  // data
    output logic                            cfg_ack_out,   // done
    output logic                            cfg_error_out, // refused
    output logic [pci_cs_pkg::REG_W-1:0]    cfg_rdata_out, // data
    input  wire logic                       parity_err_in, // data pe
    input  wire logic                       parity_master_in, // ours
    input  wire logic                       addr_parity_err_in, // ape
    input  wire logic                       serr_request_in, // err
    input  wire logic                       master_abort_in, // m-abt
    input  wire logic                       abort_special_in, // spc
    input  wire logic                       target_abort_rcvd_in, // t
    input  wire logic                       target_abort_sent_in, // t
    input  wire logic                       transfer_error_report_enable_in,
    input  wire logic                       cpu_req_in,    // to pci
    input  wire logic                       cpu_write_in,  // write
    input  wire logic                       tgt_mem_hit_in, // mem hit
    input  wire logic                       tgt_io_hit_in, // io hit
    input  wire logic                       tgt_special_in, // special
    output logic                            serr_oe_out,   // drive low
    output logic                            parity_action_out, // act
    output logic                            master_enable_out, // bit2
    output logic                            mem_enable_out, // bit 1
    output logic                            cpu_forward_out, // issue
    output logic                            cpu_discard_out, // dropped
    output logic                            transfer_error_ack_out,
    output logic                            tgt_claim_out  // claim
);
    import pci_cs_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [REG_W-1:0] cmd;
        logic             ack;
        logic             err;
        logic [REG_W-1:0] rdata;
        logic             serr_oe;
        logic             parity_action;
    } cs_state_t;

    cs_state_t        st;
    cs_state_t        next_st;
    logic [REG_W-1:0] flags;
    logic [REG_W-1:0] status_word;
    logic [REG_W-1:0] set_vec;
    logic [REG_W-1:0] clr_vec;
    logic [REG_W-1:0] wmask;
    logic             ctrl_hit;
    logic             status_hit;
    logic             status_full;
    logic             cmd_wr;
    logic             serr_en;
    logic             parity_resp;
    logic             serr_fire;
    logic             mpe_set;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [REG_W-1:0] lane_mask(
        input logic [BE_W-1:0] be
    );
        lane_mask = {{8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic [REG_W-1:0] reg_read(
        input logic [OFF_W-1:0] off,
        input logic [REG_W-1:0] cmd,
        input logic [REG_W-1:0] stat
    );
        reg_read = '0;
        if (off == OFF_BUS_CONTROL)
            reg_read = cmd & CMD_WRITABLE;
        else if (off == OFF_EVENT_FLAGS)
            reg_read = stat;
    endfunction

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    assign ctrl_hit    = cfg_offset_in == OFF_BUS_CONTROL;
    assign status_hit  = cfg_offset_in == OFF_EVENT_FLAGS;
    assign status_full = cfg_byte_en_in == BE_FULL;
    assign cmd_wr      = cfg_valid_in & cfg_write_in & ctrl_hit;
    // only the writable bits follow the data lanes
    assign wmask       = lane_mask(cfg_byte_en_in) & CMD_WRITABLE;
    assign serr_en     = st.cmd[CMD_SERR_EN];
    assign parity_resp = st.cmd[CMD_PARITY_RESP];
    assign serr_fire   = serr_en & (serr_request_in
                         | (addr_parity_err_in & parity_resp));
    assign mpe_set     = parity_err_in & parity_master_in
                         & parity_resp;

    // narrow status writes are refused, so they clear nothing
    assign clr_vec = (cfg_valid_in & cfg_write_in & status_hit
                      & status_full) ? (cfg_wdata_in & ST_STICKY)
                                     : '0;

    always_comb
    begin
        set_vec                   = '0;
        set_vec[ST_PARITY_DET]    = parity_err_in
                                    | addr_parity_err_in;
        set_vec[ST_SIG_SERR]      = st.serr_oe;
        set_vec[ST_RCV_MABORT]    = master_abort_in
                                    & ~abort_special_in;
        set_vec[ST_RCV_TABORT]    = target_abort_rcvd_in;
        set_vec[ST_SIG_TABORT]    = target_abort_sent_in;
        set_vec[ST_MASTER_PARITY] = mpe_set;
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    event_flags #(
        .WIDTH   (REG_W),
        .RST_VAL (ST_RESET)
    ) u_flags (
        .clk_sys_in (clk_sys_in),
        .srst_in    (srst_in),
        .set_in     (set_vec),
        .clear_in   (clr_vec),
        .flags_out  (flags)
    );

    // reserved and devsel bits are masked off the flags, bit 7 reads one
    assign status_word = (flags & ST_STICKY) | ST_FIXED_ONES;

    // ------------------------------------------------------------
    // access and control
    // ------------------------------------------------------------
    always_comb
    begin
        next_st               = st;
        next_st.ack           = cfg_valid_in;
        next_st.err           = 1'b0;
        next_st.rdata         = '0;
        next_st.serr_oe       = serr_fire;
        next_st.parity_action = parity_err_in & parity_resp;
        if (cfg_valid_in)
        begin
            if (status_hit && !status_full)
                next_st.err = 1'b1;
            else if (!cfg_write_in)
                next_st.rdata = reg_read(cfg_offset_in, st.cmd,
                                         status_word)
                                & lane_mask(cfg_byte_en_in);
        end
        if (cmd_wr)
            next_st.cmd = (st.cmd & ~wmask)
                          | (cfg_wdata_in & wmask);
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            st       <= '0;
            st.cmd   <= CMD_RESET;
        end
        else
            st <= next_st;
    end

    assign cfg_ack_out       = st.ack;
    assign cfg_error_out     = st.err;
    assign cfg_rdata_out     = st.rdata;
    assign serr_oe_out       = st.serr_oe;
    assign parity_action_out = st.parity_action;
    assign master_enable_out = st.cmd[CMD_MASTER_EN];
    assign mem_enable_out    = st.cmd[CMD_MEM_EN];

    // ------------------------------------------------------------
    // request gating
    // ------------------------------------------------------------
    pci_access_gate u_gate (
        .clk_sys_in     (clk_sys_in),
        .srst_in        (srst_in),
        .master_en_in   (st.cmd[CMD_MASTER_EN]),
        .mem_en_in      (st.cmd[CMD_MEM_EN]),
        .err_rep_en_in  (transfer_error_report_enable_in),
        .cpu_req_in     (cpu_req_in),
        .cpu_write_in   (cpu_write_in),
        .tgt_mem_hit_in (tgt_mem_hit_in),
        .tgt_io_hit_in  (tgt_io_hit_in),
        .tgt_spec_in    (tgt_special_in),
        .cpu_fwd_out    (cpu_forward_out),
        .cpu_drop_out   (cpu_discard_out),
        .transfer_error_ack_out (transfer_error_ack_out),
        .tgt_claim_out  (tgt_claim_out)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (srst_in);

    sequence s_flag_clear;
        cfg_valid_in && cfg_write_in && status_hit && status_full
        && set_vec == '0;
    endsequence

    sequence s_cpu_blocked;
        cpu_req_in && !st.cmd[CMD_MASTER_EN];
    endsequence

    sequence s_mem_hit_off;
        tgt_mem_hit_in && !st.cmd[CMD_MEM_EN];
    endsequence

    a_reserved_zero: assert property (
        (st.cmd & ~CMD_WRITABLE) == '0
        && (status_word & ST_RESERVED) == '0)
        else $error("reserved bit not zero");

    a_no_fast_b2b: assert property (
        !st.cmd[CMD_FAST_B2B])
        else $error("command bit 9 set");

    a_serr_gated: assert property (
        serr_oe_out |-> $past(serr_en))
        else $error("serr driven while disabled");

    a_addr_parity: assert property (
        addr_parity_err_in && serr_en && parity_resp
        |=> serr_oe_out)
        else $error("address parity not reported");

    a_parity_act: assert property (
        parity_action_out |-> $past(parity_resp)
        && $past(parity_err_in))
        else $error("parity action without response");

    a_no_mwi: assert property (
        !st.cmd[CMD_MWI])
        else $error("command bit 4 set");

    a_no_special: assert property (
        !st.cmd[CMD_SPECIAL] and (tgt_special_in |=> !tgt_claim_out))
        else $error("special cycle claimed");

    a_no_master: assert property (
        s_cpu_blocked |=> !cpu_forward_out)
        else $error("access issued while master off");

    a_blocked_write: assert property (
        s_cpu_blocked ##0 cpu_write_in |=> cpu_discard_out
        && !transfer_error_ack_out)
        else $error("blocked write not dropped");

    a_blocked_read: assert property (
        s_cpu_blocked ##0 !cpu_write_in
        |=> transfer_error_ack_out == $past(
            transfer_error_report_enable_in))
        else $error("blocked read error ack wrong");

    a_mem_ignore: assert property (
        s_mem_hit_off |=> !tgt_claim_out)
        else $error("memory claimed while disabled");

    a_no_io: assert property (
        !st.cmd[CMD_IO_EN] and (tgt_io_hit_in |=> !tgt_claim_out))
        else $error("io access claimed");

    a_narrow_refused: assert property (
        cfg_valid_in && status_hit && !status_full
        |=> cfg_error_out && cfg_ack_out)
        else $error("narrow status access accepted");

    a_w1c_clear: assert property (
        s_flag_clear |=> (flags & $past(cfg_wdata_in)) == '0)
        else $error("written one did not clear");

    a_write_no_set: assert property (
        set_vec == '0 |=> (flags & ~$past(flags)) == '0)
        else $error("flag set without event");

    a_parity_flag: assert property (
        parity_err_in |=> status_word[ST_PARITY_DET])
        else $error("parity flag missed");

    a_serr_flag: assert property (
        serr_oe_out |=> status_word[ST_SIG_SERR])
        else $error("serr flag missed");

    a_mabort_flag: assert property (
        master_abort_in && !abort_special_in
        |=> status_word[ST_RCV_MABORT])
        else $error("master abort flag missed");

    a_tabort_rcvd: assert property (
        target_abort_rcvd_in |=> status_word[ST_RCV_TABORT])
        else $error("received abort flag missed");

    a_tabort_sent: assert property (
        target_abort_sent_in |=> status_word[ST_SIG_TABORT])
        else $error("signalled abort flag missed");

    a_devsel_fast: assert property (
        (status_word & ST_DEVSEL) == '0
        and (tgt_mem_hit_in && st.cmd[CMD_MEM_EN] && !tgt_io_hit_in
            && !tgt_special_in |=> tgt_claim_out))
        else $error("devsel timing wrong");

    a_master_pe: assert property (
        $rose(status_word[ST_MASTER_PARITY]) |-> $past(mpe_set))
        else $error("master parity flag without cause");

    a_b2b_capable: assert property (
        status_word[ST_FAST_B2B_CAP])
        else $error("status bit 7 not one");

    a_fixed_kept: assert property (
        cmd_wr |=> ((st.cmd ^ $past(st.cmd)) & ~CMD_WRITABLE) == '0)
        else $error("fixed command bit changed");
endmodule // pci_command_status_regs
`default_nettype wire

// File: pci_agent_model.sv
// pci side agent: error logic, master engine and target decode pulses
// assumes the bench calls fire() from one process at a time
`timescale 1ns/1ps
`default_nettype none
module pci_agent_model (
    input  wire logic        clk_sys_in, // system clock
    output logic      [12:0] ev_out      // event and request pulses
);
    // ------------------------------------------------------------
    // pulse source
    // ------------------------------------------------------------
    // bits: 12 parity, 11 ours, 10 addr parity, 9 serr, 8 m-abort,
    // 7 special, 6 t-abort in, 5 t-abort out, 4 cpu req, 3 write,
    // 2 mem hit, 1 io hit, 0 special cycle
    initial ev_out = 13'h0000;

    // one cycle per pulse, launched off the falling edge so the
    // rising edge always samples a settled value
    task automatic fire(input logic [12:0] m);
        @(negedge clk_sys_in);
        ev_out = m;
        @(negedge clk_sys_in);
        ev_out = 13'h0000;
    endtask
endmodule // pci_agent_model
`default_nettype wire

// File: pci_command_status_regs_test.sv
// self-checking bench for the command and status register pair
// assumes one config access at a time, driven on falling edges
`timescale 1ns/1ps
`default_nettype none
module pci_command_status_regs_test;
    import pci_cs_pkg::*;
    logic clk_sys_in, srst_in, cfg_valid_in;
    logic cfg_write_in, transfer_error_report_enable_in;
    logic [7:0]  cfg_offset_in;
    logic [1:0]  cfg_byte_en_in;
    logic [15:0] cfg_wdata_in, cfg_rdata_out, rd;
    logic [12:0] ev;
    logic cfg_ack_out, cfg_error_out, serr_oe_out, parity_action_out;
    logic master_enable_out, mem_enable_out, cpu_forward_out, er;
    logic cpu_discard_out, transfer_error_ack_out, tgt_claim_out;
    logic parity_err_in, parity_master_in, addr_parity_err_in;
    logic serr_request_in, master_abort_in, abort_special_in;
    logic target_abort_rcvd_in, target_abort_sent_in, cpu_req_in;
    logic cpu_write_in, tgt_mem_hit_in, tgt_io_hit_in, tgt_special_in;
    int fail_count = 0, checked = 0;

    assign {parity_err_in, parity_master_in, addr_parity_err_in,
            serr_request_in, master_abort_in, abort_special_in,
            target_abort_rcvd_in, target_abort_sent_in, cpu_req_in,
            cpu_write_in, tgt_mem_hit_in, tgt_io_hit_in,
            tgt_special_in} = ev;

    initial clk_sys_in = 1'b0;
    always #50 clk_sys_in = ~clk_sys_in;

    pci_agent_model i_pci_agent_model (.clk_sys_in, .ev_out(ev));
    pci_command_status_regs i_pci_command_status_regs (
        .clk_sys_in, .srst_in, .cfg_valid_in, .cfg_write_in,
        .cfg_offset_in, .cfg_byte_en_in, .cfg_wdata_in, .cfg_ack_out,
        .cfg_error_out, .cfg_rdata_out, .parity_err_in, .parity_master_in,
        .addr_parity_err_in, .serr_request_in, .master_abort_in,
        .abort_special_in, .target_abort_rcvd_in, .target_abort_sent_in,
        .transfer_error_report_enable_in, .cpu_req_in, .cpu_write_in,
        .tgt_mem_hit_in, .tgt_io_hit_in, .tgt_special_in, .serr_oe_out,
        .parity_action_out, .master_enable_out, .mem_enable_out,
        .cpu_forward_out, .cpu_discard_out, .transfer_error_ack_out,
        .tgt_claim_out);

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] got, exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // answer stands for one cycle, so it is taken at the next fall
    task automatic acc(input logic w, input logic [7:0] off,
                       input logic [1:0] be, input logic [15:0] wd);
        @(negedge clk_sys_in);
        cfg_valid_in = 1'b1;
        cfg_write_in = w;
        cfg_offset_in = off;
        cfg_byte_en_in = be;
        cfg_wdata_in = wd;
        @(negedge clk_sys_in);
        cfg_valid_in = 1'b0;
        rd = cfg_rdata_out;
        er = cfg_error_out;
        chk("ack", {15'h0, cfg_ack_out}, 16'h0001);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] off,
                         input logic [15:0] exp);
        acc(1'b0, off, BE_FULL, 16'h0000);
        chk(nm, rd, exp);
        chk("err", {15'h0, er}, 16'h0000);
    endtask

    task automatic pulse(input string nm, input logic [12:0] m,
                         input logic got_sel, input logic exp);
        i_pci_agent_model.fire(m);
        chk(nm, {15'h0, got_sel ? serr_oe_out : tgt_claim_out},
            {15'h0, exp});
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        #500000;
        fail_count++;
        end_sim();
    end

    initial
    begin
        srst_in = 1'b1;
        {cfg_valid_in, cfg_write_in} = 2'h0;
        transfer_error_report_enable_in = 1'b0;
        {cfg_offset_in, cfg_byte_en_in, cfg_wdata_in} = 26'h0;
        repeat (20) @(negedge clk_sys_in);
        srst_in = 1'b0;
        rdchk("ctl_rst", OFF_BUS_CONTROL, 16'h0006);
        rdchk("st_rst", OFF_EVENT_FLAGS, 16'h0080);
        acc(1'b1, OFF_BUS_CONTROL, BE_FULL, 16'hffff);
        rdchk("ctl_fix", OFF_BUS_CONTROL, 16'h0146);
        acc(1'b1, OFF_EVENT_FLAGS, BE_FULL, 16'hffff);
        rdchk("st_fix", OFF_EVENT_FLAGS, 16'h0080);
        i_pci_agent_model.fire(13'h1800);
        chk("par_act", {15'h0, parity_action_out}, 16'h0001);
        rdchk("st_par", OFF_EVENT_FLAGS, 16'h8180);
        pulse("serr", 13'h0200, 1'b1, 1'b1);
        i_pci_agent_model.fire(13'h0180);
        rdchk("st_spc", OFF_EVENT_FLAGS, 16'hc180);
        i_pci_agent_model.fire(13'h0100);
        i_pci_agent_model.fire(13'h0040);
        i_pci_agent_model.fire(13'h0020);
        rdchk("st_abt", OFF_EVENT_FLAGS, 16'hf980);
        acc(1'b1, OFF_EVENT_FLAGS, 2'h1, 16'hffff);
        chk("narrow", {15'h0, er}, 16'h0001);
        acc(1'b1, OFF_EVENT_FLAGS, BE_FULL, 16'h4000);
        rdchk("w1c", OFF_EVENT_FLAGS, 16'hb980);
        acc(1'b1, OFF_EVENT_FLAGS, BE_FULL, 16'hffff);
        acc(1'b1, OFF_BUS_CONTROL, BE_FULL, 16'h0000);
        chk("mst_en", {15'h0, master_enable_out}, 16'h0000);
        chk("mem_en", {15'h0, mem_enable_out}, 16'h0000);
        i_pci_agent_model.fire(13'h1800);
        chk("par_off", {15'h0, parity_action_out}, 16'h0000);
        rdchk("st_nor", OFF_EVENT_FLAGS, 16'h8080);
        pulse("ape_off", 13'h0400, 1'b1, 1'b0);
        pulse("serr_off", 13'h0200, 1'b1, 1'b0);
        i_pci_agent_model.fire(13'h0018);
        chk("drop", {15'h0, cpu_discard_out}, 16'h0001);
        i_pci_agent_model.fire(13'h0010);
        chk("ack_off", {15'h0, transfer_error_ack_out}, 16'h0000);
        transfer_error_report_enable_in = 1'b1;
        i_pci_agent_model.fire(13'h0010);
        chk("err_ack", {15'h0, transfer_error_ack_out}, 16'h0001);
        pulse("mem_off", 13'h0004, 1'b0, 1'b0);
        acc(1'b1, OFF_BUS_CONTROL, BE_FULL, 16'h0146);
        pulse("mem_on", 13'h0004, 1'b0, 1'b1);
        pulse("io", 13'h0006, 1'b0, 1'b0);
        pulse("spc", 13'h0005, 1'b0, 1'b0);
        pulse("ape_on", 13'h0400, 1'b1, 1'b1);
        acc(1'b1, OFF_BUS_CONTROL, 2'h1, 16'h0000);
        rdchk("ctl_lane", OFF_BUS_CONTROL, 16'h0100);
        pulse("ape_half", 13'h0400, 1'b1, 1'b0);
        pulse("serr_on", 13'h0200, 1'b1, 1'b1);
        acc(1'b1, OFF_BUS_CONTROL, BE_FULL, 16'h0146);
        i_pci_agent_model.fire(13'h0010);
        chk("fwd", {15'h0, cpu_forward_out}, 16'h0001);
        rdchk("unmap", 8'h08, 16'h0000);
        end_sim();
    end
endmodule // pci_command_status_regs_test
`default_nettype wire
